// [design/memctl.sv]
// controller driving a two-bank cached dram module through its strobe pins
// assumes the module follows strobe edges; read data pins are asynchronous
module memctl #(
    parameter int ROW_W = memctl_pkg::ROW_W,
    parameter int COL_W = memctl_pkg::COL_W,
    parameter int DATA_W = memctl_pkg::DATA_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [1:0] i_req_op,
    input wire logic i_req_bank,
    input wire logic [ROW_W-1:0] i_req_row,
    input wire logic [COL_W-1:0] i_req_col,
    input wire logic [DATA_W-1:0] i_req_wdata,
    output logic o_rsp_valid,
    output logic [DATA_W-1:0] o_rsp_rdata,
    output logic o_init_done,
    output logic [1:0] o_row_strobe_n,
    output logic o_col_strobe_n,
    output logic o_wr_rd,
    output logic o_refresh_n,
    output logic o_write_n,
    output logic o_gate_n,
    output logic [1:0] o_cs_n,
    output logic [ROW_W-1:0] o_mux_addr,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq,
    output logic o_dq_oe
);
    if (ROW_W != memctl_pkg::ROW_W || COL_W > ROW_W ||
        DATA_W < 1) begin : g_bad_width
        $error("memctl: unsupported widths");
    end

    typedef struct packed {
        logic [1:0] rst_sync;
        memctl_pkg::state_t st;
        logic [memctl_pkg::CNT_W-1:0] cnt;
        logic [3:0] init_n;
        logic [1:0] op;
        logic bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] wdata;
        logic [1:0] open_valid;
        logic [ROW_W-1:0] open_row0;
        logic [ROW_W-1:0] open_row1;
        logic [1:0] re_n;
        logic cal_n;
        logic wr_rd;
        logic ref_n;
        logic we_n;
        logic g_n;
        logic [1:0] cs_n;
        logic [ROW_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic done;
        logic [DATA_W-1:0] dq_s1;
        logic [DATA_W-1:0] dq_s2;
        logic [DATA_W-1:0] dq_s3;
    } state_reg_t;

    state_reg_t cur_ff;
    state_reg_t nxt_ff;
    logic rst_int_n;
    logic hit;

    assign rst_int_n = cur_ff.rst_sync[1];
    assign hit = cur_ff.bank ? (cur_ff.open_valid[1] &&
                                cur_ff.open_row1 == cur_ff.row)
                             : (cur_ff.open_valid[0] &&
                                cur_ff.open_row0 == cur_ff.row);

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rst_sync = {cur_ff.rst_sync[0], 1'b1};
        nxt_ff.rsp_valid = 1'b0;
        // data pins are asynchronous: third stage only counts once it agrees
        nxt_ff.dq_s1 = i_dq;
        nxt_ff.dq_s2 = cur_ff.dq_s1;
        nxt_ff.dq_s3 = cur_ff.dq_s2;
        if (cur_ff.cnt != '0)
            nxt_ff.cnt = cur_ff.cnt - 1'b1;
        case (cur_ff.st)
            memctl_pkg::ST_INIT: begin
                if (cur_ff.cnt == '0) begin
                    if (cur_ff.init_n < 4'(memctl_pkg::INIT_REF)) begin
                        nxt_ff.op = memctl_pkg::OP_REFRESH;
                        nxt_ff.bank = 1'b0;
                        nxt_ff.st = memctl_pkg::ST_SETUP;
                    end else begin
                        nxt_ff.op = memctl_pkg::OP_READ;
                        nxt_ff.bank = 1'b0;
                        nxt_ff.row = ROW_W'(cur_ff.init_n);
                        nxt_ff.col = '0;
                        nxt_ff.st = memctl_pkg::ST_SETUP;
                    end
                    nxt_ff.init_n = cur_ff.init_n + 1'b1;
                    nxt_ff.cnt = 8'(memctl_pkg::SU_CYC);
                    nxt_ff.cs_n = 2'h3;
                    nxt_ff.cs_n[0] = nxt_ff.op == memctl_pkg::OP_REFRESH;
                    nxt_ff.ref_n = nxt_ff.op != memctl_pkg::OP_REFRESH;
                    nxt_ff.wr_rd = 1'b0;
                    nxt_ff.addr = nxt_ff.row;
                end
            end
            memctl_pkg::ST_IDLE: begin
                nxt_ff.cs_n = 2'h3;
                nxt_ff.g_n = 1'b1;
                if (i_req_valid) begin
                    nxt_ff.op = i_req_op;
                    nxt_ff.bank = i_req_bank;
                    nxt_ff.row = i_req_row;
                    nxt_ff.col = i_req_col;
                    nxt_ff.wdata = i_req_wdata;
                    // refresh needs no bank selected
                    if (i_req_op != memctl_pkg::OP_REFRESH)
                        nxt_ff.cs_n[i_req_bank] = 1'b0;
                    nxt_ff.ref_n = i_req_op != memctl_pkg::OP_REFRESH;
                    nxt_ff.wr_rd = i_req_op != memctl_pkg::OP_READ;
                    nxt_ff.addr = i_req_row;
                    nxt_ff.cnt = 8'(memctl_pkg::SU_CYC);
                    nxt_ff.st = memctl_pkg::ST_SETUP;
                    if (i_req_op == memctl_pkg::OP_MASK) begin
                        nxt_ff.dq = i_req_wdata;
                        nxt_ff.dq_oe = 1'b1;
                    end
                end
            end
            memctl_pkg::ST_SETUP: begin
                if (cur_ff.cnt == '0) begin
                    if (cur_ff.op == memctl_pkg::OP_READ && hit &&
                        !(cur_ff.init_n <= 4'(memctl_pkg::INIT_REF +
                                             memctl_pkg::INIT_RD) &&
                          !cur_ff.done)) begin
                        nxt_ff.addr = ROW_W'(cur_ff.col);
                        nxt_ff.g_n = 1'b0;
                        nxt_ff.cnt = 8'(memctl_pkg::AC_CYC);
                        nxt_ff.st = memctl_pkg::ST_READ;
                    end else begin
                        // column strobe high here except refresh
                        nxt_ff.cal_n = cur_ff.op != memctl_pkg::OP_REFRESH;
                        nxt_ff.re_n[cur_ff.bank] = 1'b0;
                        nxt_ff.cnt = 8'(memctl_pkg::SU_CYC);
                        nxt_ff.st = memctl_pkg::ST_ROW;
                    end
                end
            end
            memctl_pkg::ST_ROW: begin
                if (cur_ff.cnt == '0) begin
                    nxt_ff.ref_n = 1'b1;
                    nxt_ff.wr_rd = 1'b0;
                    nxt_ff.dq_oe = 1'b0;
                    nxt_ff.addr = ROW_W'(cur_ff.col);
                    case (cur_ff.op)
                        memctl_pkg::OP_READ: begin
                            // writes and refresh leave the cache row alone
                            if (cur_ff.bank)
                                nxt_ff.open_row1 = cur_ff.row;
                            else
                                nxt_ff.open_row0 = cur_ff.row;
                            nxt_ff.open_valid[cur_ff.bank] = 1'b1;
                            nxt_ff.g_n = 1'b0;
                            nxt_ff.cnt = 8'(memctl_pkg::RE_CYC);
                            nxt_ff.st = memctl_pkg::ST_READ;
                        end
                        memctl_pkg::OP_WRITE: begin
                            nxt_ff.dq = cur_ff.wdata;
                            nxt_ff.dq_oe = 1'b1;
                            nxt_ff.cnt = 8'(memctl_pkg::SU_CYC);
                            nxt_ff.st = memctl_pkg::ST_COL;
                        end
                        default: begin
                            nxt_ff.cnt = 8'(memctl_pkg::RE_CYC);
                            nxt_ff.st = memctl_pkg::ST_PRECH;
                        end
                    endcase
                end
            end
            memctl_pkg::ST_COL: begin
                if (cur_ff.cnt == '0) begin
                    nxt_ff.cal_n = 1'b0; // column latched
                    nxt_ff.we_n = 1'b0;
                    nxt_ff.cnt = 8'(memctl_pkg::WR_CYC);
                    nxt_ff.st = memctl_pkg::ST_WRITE;
                end
            end
            memctl_pkg::ST_WRITE: begin
                if (cur_ff.cnt == '0) begin
                    nxt_ff.we_n = 1'b1;
                    nxt_ff.cal_n = 1'b1;
                    nxt_ff.dq_oe = 1'b0;
                    nxt_ff.cnt = 8'(memctl_pkg::RE_CYC);
                    nxt_ff.st = memctl_pkg::ST_PRECH;
                end
            end
            memctl_pkg::ST_READ: begin
                // row strobe rises early once the row sits in cache
                nxt_ff.re_n = 2'h3;
                // a hit is short: wait until the last two stages agree
                if (cur_ff.cnt == '0 && cur_ff.dq_s2 == cur_ff.dq_s3) begin
                    nxt_ff.rdata = cur_ff.dq_s3;
                    nxt_ff.g_n = 1'b1;
                    nxt_ff.rsp_valid = cur_ff.done;
                    nxt_ff.cnt = 8'(memctl_pkg::RP_CYC);
                    nxt_ff.st = memctl_pkg::ST_PRECH;
                end
            end
            memctl_pkg::ST_PRECH: begin
                nxt_ff.re_n = 2'h3;
                nxt_ff.cal_n = 1'b1;
                nxt_ff.ref_n = 1'b1;
                if (cur_ff.cnt == '0) begin
                    nxt_ff.cnt = 8'(memctl_pkg::RP_CYC);
                    nxt_ff.cs_n = 2'h3;
                    if (cur_ff.done)
                        nxt_ff.st = memctl_pkg::ST_IDLE;
                    else if (cur_ff.init_n >= 4'(memctl_pkg::INIT_REF +
                                                memctl_pkg::INIT_RD))
                        nxt_ff.st = memctl_pkg::ST_DONE;
                    else
                        nxt_ff.st = memctl_pkg::ST_INIT;
                end
            end
            memctl_pkg::ST_DONE: begin
                nxt_ff.done = 1'b1;
                nxt_ff.st = memctl_pkg::ST_IDLE;
            end
            default: nxt_ff.st = memctl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_ff <= '0;
            cur_ff.st <= memctl_pkg::ST_INIT;
            cur_ff.cnt <= 8'(memctl_pkg::INIT_CYC);
            cur_ff.re_n <= 2'h3;
            cur_ff.cal_n <= 1'b1;
            cur_ff.ref_n <= 1'b1;
            cur_ff.we_n <= 1'b1;
            cur_ff.g_n <= 1'b1;
            cur_ff.cs_n <= 2'h3;
        end else if (!rst_int_n) begin
            cur_ff.rst_sync <= nxt_ff.rst_sync;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign o_req_ready = cur_ff.st == memctl_pkg::ST_IDLE;
    assign o_rsp_valid = cur_ff.rsp_valid;
    assign o_rsp_rdata = cur_ff.rdata;
    assign o_init_done = cur_ff.done;
    assign o_row_strobe_n = cur_ff.re_n;
    assign o_col_strobe_n = cur_ff.cal_n;
    assign o_wr_rd = cur_ff.wr_rd;
    assign o_refresh_n = cur_ff.ref_n;
    assign o_write_n = cur_ff.we_n;
    assign o_gate_n = cur_ff.g_n;
    assign o_cs_n = cur_ff.cs_n;
    assign o_mux_addr = cur_ff.addr;
    assign o_dq = cur_ff.dq;
    assign o_dq_oe = cur_ff.dq_oe;
endmodule // memctl

// [design/memctl_pkg.sv]
// constants and types for the strobe-driving memory controller
// assumes a 125 MHz system clock and one module with two banks on the pins
package memctl_pkg;
    localparam int ROW_W = 11;
    localparam int COL_W = 9;
    localparam int DATA_W = 36;
    localparam int CLK_MHZ = 125;
    localparam int CLK_PS = 8000;
    localparam int T_INIT_NS = 300;
    localparam int T_RE_NS = 30;
    localparam int T_RP_NS = 20;
    localparam int T_AC_NS = 12;
    localparam int T_WR_NS = 12;
    localparam int T_SU_NS = 5;
    // least times round up
    localparam int INIT_CYC = (T_INIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RE_CYC = (T_RE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int AC_CYC = (T_AC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WR_CYC = (T_WR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SU_CYC = (T_SU_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int INIT_REF = 8;
    localparam int INIT_RD = 2;
    localparam int CNT_W = 8;
    typedef enum logic [9:0] {
        ST_INIT   = 10'h001,
        ST_IDLE   = 10'h002,
        ST_SETUP  = 10'h004,
        ST_ROW    = 10'h008,
        ST_COL    = 10'h010,
        ST_WRITE  = 10'h020,
        ST_READ   = 10'h040,
        ST_PRECH  = 10'h080,
        ST_INITRD = 10'h100,
        ST_DONE   = 10'h200
    } state_t;
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_REFRESH = 2'h2,
        OP_MASK = 2'h3
    } op_t;
endpackage

// [tb/dram_model.sv]
// behavioural two-bank cached memory module on the controller pins
// assumes the bench resolves the shared data pins from both enables
module dram_model (
    input wire logic [1:0] i_row_strobe_n,
    input wire logic i_col_strobe_n,
    input wire logic i_wr_rd,
    input wire logic i_refresh_n,
    input wire logic i_write_n,
    input wire logic i_gate_n,
    input wire logic [1:0] i_cs_n,
    input wire logic [10:0] i_mux_addr,
    input wire logic [35:0] i_dq,
    input wire logic i_dq_drv,
    output logic [35:0] o_dq,
    output logic o_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [logic [20:0]];
    logic [10:0] open_row [2];
    logic [10:0] wr_row [2];
    logic [8:0] col_ff;
    logic [35:0] mask = 36'hF_FFFF_FFFF;
    logic [10:0] ref_cnt = 11'h000;
    logic [20:0] key;
    logic [20:0] wr_key;
    // cache row of the selected bank answers every read
    assign key = {i_cs_n[0], open_row[i_cs_n[0]], col_ff};
    // writes go to the latched row, hit or miss; store stays coherent
    assign wr_key = {i_cs_n[0], wr_row[i_cs_n[0]], col_ff};
    always @(i_col_strobe_n or i_mux_addr)
        if (i_col_strobe_n) col_ff = i_mux_addr[8:0];
    task automatic row_fall(input int b);
        if (!i_refresh_n) ref_cnt = ref_cnt + 11'h001;
        else if (!i_cs_n[b]) begin
            wr_row[b] = i_mux_addr;
            if (!i_wr_rd) open_row[b] = i_mux_addr;
            else if (i_dq_drv) mask = i_dq;
        end
    endtask
    always @(negedge i_row_strobe_n[0]) row_fall(0);
    always @(negedge i_row_strobe_n[1]) row_fall(1);
    always @(negedge i_write_n or negedge i_col_strobe_n)
        if (!i_write_n && !i_col_strobe_n && i_cs_n != 2'h3)
            mem[wr_key] = (i_dq & mask) |
                ((mem.exists(wr_key) ? mem[wr_key] : 36'h0) & ~mask);
    always @* begin
        o_dq_oe = !i_gate_n && !i_wr_rd && i_cs_n != 2'h3;
        o_dq = mem.exists(key) ? mem[key] : 36'h0;
        // released pins show the inverse so a stale value cannot pass
        if (!o_dq_oe) o_dq = ~o_dq;
    end
endmodule // dram_model

// [tb/memctl_checker.sv]
// pin checker for the strobe-driving memory controller
// assumes bind onto memctl; sees only its ports
module memctl_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic o_init_done,
    input wire logic [1:0] o_row_strobe_n,
    input wire logic o_col_strobe_n,
    input wire logic o_refresh_n,
    input wire logic o_write_n,
    input wire logic o_gate_n,
    input wire logic [1:0] o_cs_n,
    input wire logic o_dq_oe
);
    logic [7:0] up_cnt;
    logic [4:0] n_fall;
    logic [4:0] n_ref;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_cnt <= 8'h00;
            n_fall <= 5'h00;
            n_ref <= 5'h00;
        end else begin
            if (up_cnt != 8'hFF) up_cnt <= up_cnt + 8'h01;
            // any bank going low counts as one start-up cycle
            if (|($past(o_row_strobe_n) & ~o_row_strobe_n)) begin
                if (n_fall != 5'h1F) n_fall <= n_fall + 5'h01;
                if (!o_refresh_n && n_ref != 5'h1F) n_ref <= n_ref + 5'h01;
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence open0_s;
        $fell(o_row_strobe_n[0]) && o_refresh_n;
    endsequence
    sequence open1_s;
        $fell(o_row_strobe_n[1]) && o_refresh_n;
    endsequence
    sequence open_any_s;
        ($fell(o_row_strobe_n[0]) || $fell(o_row_strobe_n[1])) && o_refresh_n;
    endsequence
    bank0_select_a: assert property (open0_s |-> o_cs_n == 2'h2)
        else $error("bank 0 strobe without its select");
    bank1_select_a: assert property (open1_s |-> o_cs_n == 2'h1)
        else $error("bank 1 strobe without its select");
    bank0_hold_a: assert property (open0_s |-> !o_cs_n[0] [*6])
        else $error("bank 0 select dropped early");
    bank1_hold_a: assert property (open1_s |-> !o_cs_n[1] [*6])
        else $error("bank 1 select dropped early");
    col_high_a: assert property (open_any_s |-> o_col_strobe_n)
        else $error("column strobe low at row strobe fall");
    init_quiet_a: assert property (up_cnt < memctl_pkg::INIT_CYC |->
        o_row_strobe_n == 2'h3) else $error("row strobe before start-up");
    init_count_a: assert property ($rose(o_init_done) |->
        n_fall >= 5'h0A && n_ref >= 5'h08) else $error("start-up too short");
    no_clash_a: assert property (o_dq_oe |-> o_gate_n)
        else $error("output gate open while driving data");
    write_data_a: assert property (!o_write_n && !o_col_strobe_n |->
        o_dq_oe && o_cs_n != 2'h3) else $error("write without data");
endmodule // memctl_checker
bind memctl memctl_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .o_init_done(o_init_done), .o_row_strobe_n(o_row_strobe_n),
    .o_col_strobe_n(o_col_strobe_n), .o_refresh_n(o_refresh_n),
    .o_write_n(o_write_n), .o_gate_n(o_gate_n), .o_cs_n(o_cs_n),
    .o_dq_oe(o_dq_oe));

// [tb/test_cached_dram_module_strobe_interface.sv]
// self-checking bench for the strobe-driving memory controller
// assumes the device model and the bound pin checker
module test_cached_dram_module_strobe_interface;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
    typedef struct {
        logic [1:0] op;
        logic b;
        logic [10:0] r;
        logic [8:0] c;
        logic [35:0] d;
    } case_t;
    logic i_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_bank = 0;
    logic [1:0] i_req_op = 2'h0;
    logic [10:0] i_req_row = 11'h000;
    logic [8:0] i_req_col = 9'h000;
    logic [35:0] i_req_wdata = 36'h0, rdata, ctl_dq, dev_dq, dq_bus;
    logic ready, rsp, done, col_n, wr_rd, ref_n, wr_n, gate_n, ctl_oe, dev_oe;
    logic [1:0] row_n, cs_n;
    logic [10:0] addr;
    int n_fail = 0, cmp_count = 0;
    // op codes: 0 read, 1 write, 2 refresh, 3 mask load
    case_t rows [10] = '{
        '{2'h1, 1'b0, 11'h005, 9'h003, 36'h1_2345_6789},
        '{2'h1, 1'b1, 11'h005, 9'h003, 36'hE_DCBA_9876},
        '{2'h0, 1'b0, 11'h005, 9'h003, 36'h1_2345_6789},
        '{2'h0, 1'b1, 11'h005, 9'h003, 36'hE_DCBA_9876},
        '{2'h0, 1'b0, 11'h005, 9'h003, 36'h1_2345_6789},
        '{2'h1, 1'b0, 11'h7FF, 9'h1FF, 36'hA_5A5A_5A5A},
        '{2'h0, 1'b0, 11'h005, 9'h003, 36'h1_2345_6789},
        '{2'h0, 1'b0, 11'h7FF, 9'h1FF, 36'hA_5A5A_5A5A},
        '{2'h2, 1'b0, 11'h000, 9'h000, 36'h0},
        '{2'h0, 1'b1, 11'h005, 9'h003, 36'hE_DCBA_9876}};
    assign dq_bus = dev_oe ? dev_dq : ctl_oe ? ctl_dq : dev_dq;
    always #4 i_clk = ~i_clk;
    memctl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
        .o_req_ready(ready), .i_req_op(i_req_op), .i_req_bank(i_req_bank),
        .i_req_row(i_req_row), .i_req_col(i_req_col),
        .i_req_wdata(i_req_wdata), .o_rsp_valid(rsp), .o_rsp_rdata(rdata),
        .o_init_done(done), .o_row_strobe_n(row_n), .o_col_strobe_n(col_n),
        .o_wr_rd(wr_rd), .o_refresh_n(ref_n), .o_write_n(wr_n),
        .o_gate_n(gate_n), .o_cs_n(cs_n), .o_mux_addr(addr), .i_dq(dq_bus),
        .o_dq(ctl_dq), .o_dq_oe(ctl_oe));
    dram_model u_mem (.i_row_strobe_n(row_n), .i_col_strobe_n(col_n),
        .i_wr_rd(wr_rd), .i_refresh_n(ref_n), .i_write_n(wr_n),
        .i_gate_n(gate_n), .i_cs_n(cs_n), .i_mux_addr(addr), .i_dq(dq_bus),
        .i_dq_drv(ctl_oe), .o_dq(dev_dq), .o_dq_oe(dev_oe));
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_init;
        int n;
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge i_clk);
        `CHK(done, 1'b1)
    endtask
    // called at a falling edge; holds the request until it is taken
    task automatic do_req(input case_t t, input bit chk);
        int n;
        for (n = 0; n < 500 && ready !== 1'b1; n++) @(negedge i_clk);
        i_req_valid = 1'b1;
        i_req_op = t.op;
        i_req_bank = t.b;
        i_req_row = t.r;
        i_req_col = t.c;
        i_req_wdata = t.d;
        @(posedge i_clk);
        @(negedge i_clk);
        i_req_valid = 1'b0;
        if (chk && t.op == 2'h0) begin
            for (n = 0; n < 100 && rsp !== 1'b1; n++) @(negedge i_clk);
            `CHK(rdata, t.d)
        end
    endtask
    initial begin
        #100us;
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        give_verdict;
    end
    initial begin
        repeat (5) @(negedge i_clk);
        i_rst_n = 1'b1;
        wait_init;
        foreach (rows[k]) begin
            do_req(rows[k], 1'b1);
            $display("row %0d done", k);
        end
        `CHK(u_mem.ref_cnt, 11'h009)
        // reset in the middle of a read, then memory must survive
        do_req(rows[7], 1'b0);
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b0;
        @(negedge i_clk);
        `CHK(row_n, 2'h3)
        `CHK(cs_n, 2'h3)
        `CHK(ctl_oe, 1'b0)
        repeat (5) @(negedge i_clk);
        i_rst_n = 1'b1;
        wait_init;
        do_req(rows[2], 1'b1);
        $display("reset mid-read done");
        // write-per-bit: only mask bits of a fresh word take the data
        do_req('{2'h3, 1'b0, 11'h020, 9'h001, 36'h0_0000_FFFF}, 1'b0);
        do_req('{2'h1, 1'b0, 11'h030, 9'h002, 36'hF_FFFF_FFFF}, 1'b0);
        do_req('{2'h0, 1'b0, 11'h030, 9'h002, 36'h0_0000_FFFF}, 1'b1);
        $display("mask load done");
        give_verdict;
    end
endmodule // test_cached_dram_module_strobe_interface
